// ===== verilog/tccp_timer16.sv
/*
  Compare, capture and PWM part of a 16-bit timer with its counter,
  reached over APB. Assumes count_en is a prescaled enable on the same
  clock, gie comes from the core, and capture_input_pin is asynchronous.
*/
`timescale 1ns/1ps

// Notes on behaviour
// - match only when counter counts onto value
// - software writes never produce a match
// - compare flag set one cycle after match
// - high byte parked, low write updates both
// - capture copies counter and sets flag together
// - capture low read loads high into holding
// - capture is read-only, writes ignored
// - one holding byte shared by capture and both compares
// - phase-correct counts up to top, down
// - resolution select gives top 255/511/1023
// - PWM compares only low resolution bits
// - clear-on-match in PWM wraps at top
// - bits above resolution forced to zero
// - phase-correct pin modes 10 and 11
// - wrap-mode pin modes 10 and 11
// - PWM compare writes buffered until top
// - compare reads return buffered value
// - phase-correct zero/top give fixed levels
// - wrap-mode constant level only at top
// - overflow flag per PWM mode
// - flags request interrupt when both enabled
// - select 00 off, 01/10/11 8/9/10-bit
// - edge select 0 falling, 1 rising
// - filter needs four equal samples
module tccp_timer16 (
  input logic clock,
  input logic nrst,
  input logic ce,
  input logic count_en,
  input logic gie,
  input logic capture_input_pin,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [tccp_pkg::ADDR_W-1:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic compare_out_a,
  output logic compare_out_a_oe,
  output logic compare_out_b,
  output logic compare_out_b_oe,
  output logic irq_overflow,
  output logic irq_compare_a,
  output logic irq_compare_b,
  output logic irq_capture
);

  // ==========================================================
  // helpers
  function automatic logic [15:0] top_of(input logic [1:0] sel);
    logic [15:0] t;
    t = tccp_pkg::CNT_MAX;
    case (sel)
      tccp_pkg::PWM_8: t = tccp_pkg::TOP_8;
      tccp_pkg::PWM_9: t = tccp_pkg::TOP_9;
      tccp_pkg::PWM_10: t = tccp_pkg::TOP_10;
      default: t = tccp_pkg::CNT_MAX;
    endcase
    return t;
  endfunction

  // non-inverted pin level after a counter step
  function automatic logic lvl_next(input logic cur, input logic phase,
      input logic step, input logic [15:0] cmp, input logic [15:0] top,
      input logic [15:0] cnt, input logic [15:0] nxt);
    logic r;
    r = cur;
    if (step && phase && nxt == cmp) begin
      if (cmp == tccp_pkg::REG16_RST) begin
        r = 1'b0;
      end else if (cmp == top) begin
        r = 1'b1;
      end else begin
        r = (nxt < cnt);
      end
    end else if (step && !phase) begin
      if (cnt == top) begin
        r = 1'b1;
      end else if (cnt == cmp) begin
        r = 1'b0;
      end
    end
    return r;
  endfunction

  // ==========================================================
  // state
  logic [7:0] ctrl_a_r, ctrl_b_r;
  logic [3:0] ien_r, flags_r, flags_nxt, irq_r;
  logic [15:0] cnt_r, cnt_nxt, cap_val_r;
  logic [15:0] cmp_act_r [2];
  logic [15:0] cmp_buf_r [2];
  logic [15:0] cmp_eff [2];
  logic [1:0] hit, match_r, lvl_r, out_r, oe_r;
  logic [7:0] temp_r, rd_mux;
  logic dir_up_r, dir_nxt;
  logic cap_s1_r, cap_s2_r, cap_lvl_r, cap_prev_r, cap_edge;
  logic [3:0] cap_hist_r;
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r;

  // ==========================================================
  // decode of mode bits
  logic [1:0] pwm_sel, mode_a, mode_b;
  logic pwm_on, wrap_mode, phase_mode, step, clr_hit, cnt_move, ovf_ev;
  logic latch_go;
  logic [15:0] top, mask;

  assign pwm_sel = ctrl_a_r[tccp_pkg::CA_PWM_HI:tccp_pkg::CA_PWM_LO];
  assign mode_a = ctrl_a_r[tccp_pkg::CA_MODE_A_HI:tccp_pkg::CA_MODE_A_LO];
  assign mode_b = ctrl_a_r[tccp_pkg::CA_MODE_B_HI:tccp_pkg::CA_MODE_B_LO];
  assign pwm_on = (pwm_sel != tccp_pkg::PWM_OFF);
  assign top = top_of(pwm_sel);
  assign mask = top;
  assign wrap_mode = pwm_on && ctrl_b_r[tccp_pkg::CB_CLR_MATCH];
  assign phase_mode = pwm_on && !ctrl_b_r[tccp_pkg::CB_CLR_MATCH];
  assign step = count_en;
  assign clr_hit = !pwm_on && ctrl_b_r[tccp_pkg::CB_CLR_MATCH] && match_r[0];
  assign cnt_move = step && !clr_hit;
  assign latch_go = pwm_on && step && (cnt_nxt == top);

  // ==========================================================
  // counter next value
  always_comb begin
    cnt_nxt = cnt_r;
    dir_nxt = dir_up_r;
    if (!pwm_on || wrap_mode) begin
      dir_nxt = 1'b1;
      if (clr_hit) begin
        cnt_nxt = tccp_pkg::REG16_RST;
      end else if (step && wrap_mode && cnt_r >= top) begin
        cnt_nxt = tccp_pkg::REG16_RST;
      end else if (step) begin
        cnt_nxt = 16'(cnt_r + 16'h0001);
      end
    end else if (step) begin
      if (dir_up_r && cnt_r >= top) begin
        cnt_nxt = 16'(cnt_r - 16'h0001);
        dir_nxt = 1'b0;
      end else if (dir_up_r) begin
        cnt_nxt = 16'(cnt_r + 16'h0001);
      end else if (cnt_r == tccp_pkg::REG16_RST) begin
        cnt_nxt = 16'(cnt_r + 16'h0001);
        dir_nxt = 1'b1;
      end else begin
        cnt_nxt = 16'(cnt_r - 16'h0001);
      end
    end
    cnt_nxt = cnt_nxt & mask;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= tccp_pkg::REG16_RST;
      dir_up_r <= 1'b1;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
      dir_up_r <= dir_nxt;
    end
  end

  // ==========================================================
  // compare events: only a counting step can land on the value
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      cmp_eff[i] = cmp_act_r[i] & mask;
      hit[i] = cnt_move && (cnt_nxt == cmp_eff[i]);
    end
    if (phase_mode) begin
      ovf_ev = step && (cnt_r == tccp_pkg::REG16_RST);
    end else if (wrap_mode) begin
      ovf_ev = step && (cnt_r == top);
    end else begin
      ovf_ev = cnt_move && (cnt_r == tccp_pkg::CNT_MAX);
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      match_r <= 2'b00;
    end else if (ce) begin
      match_r <= hit;
    end
  end

  // ==========================================================
  // pwm output pins
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      lvl_r <= 2'b00;
      out_r <= 2'b00;
      oe_r <= 2'b00;
    end else if (ce) begin
      for (int i = 0; i < 2; i++) begin
        logic l;
        logic [1:0] m;
        l = lvl_next(lvl_r[i], phase_mode, step, cmp_eff[i], top,
                     cnt_r, cnt_nxt);
        m = (i == 0) ? mode_a : mode_b;
        if (!pwm_on) begin
          l = lvl_r[i];
        end
        lvl_r[i] <= l;
        out_r[i] <= l ^ m[0];
        oe_r[i] <= pwm_on && m[1];
      end
    end
  end

  // ==========================================================
  // capture input: sync, optional four-sample filter, edge
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cap_s1_r <= 1'b0;
      cap_s2_r <= 1'b0;
      cap_hist_r <= tccp_pkg::FILT_ALL_LO;
      cap_lvl_r <= 1'b0;
      cap_prev_r <= 1'b0;
    end else if (ce) begin
      cap_s1_r <= capture_input_pin;
      cap_s2_r <= cap_s1_r;
      cap_hist_r <= {cap_hist_r[2:0], cap_s2_r};
      cap_prev_r <= cap_lvl_r;
      if (!ctrl_b_r[tccp_pkg::CB_FILTER]) begin
        cap_lvl_r <= cap_s2_r;
      end else if (cap_hist_r == tccp_pkg::FILT_ALL_HI) begin
        cap_lvl_r <= 1'b1;
      end else if (cap_hist_r == tccp_pkg::FILT_ALL_LO) begin
        cap_lvl_r <= 1'b0;
      end
    end
  end

  assign cap_edge = (cap_lvl_r != cap_prev_r) &&
                    (cap_lvl_r == ctrl_b_r[tccp_pkg::CB_EDGE]);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cap_val_r <= tccp_pkg::REG16_RST;
    end else if (ce && cap_edge) begin
      cap_val_r <= cnt_r;
    end
  end

  // ==========================================================
  // apb slave
  logic acc, rd_go, wr_go, mapped;
  logic [5:0] idx;

  assign idx = paddr[7:2];
  assign acc = psel && penable;
  assign rd_go = acc && !pready_r && !pwrite;
  assign wr_go = acc && pready_r && pwrite;
  assign mapped = (paddr[1:0] == 2'b00) &&
                  ((idx >= tccp_pkg::IDX_CAP_LO &&
                    idx <= tccp_pkg::IDX_CMPA_HI) ||
                   idx == tccp_pkg::IDX_CTRL_A ||
                   idx == tccp_pkg::IDX_CTRL_B ||
                   idx == tccp_pkg::IDX_FLAGS ||
                   idx == tccp_pkg::IDX_IEN);

  always_comb begin
    rd_mux = 8'h00;
    case (idx)
      tccp_pkg::IDX_CAP_LO: rd_mux = cap_val_r[7:0];
      tccp_pkg::IDX_CAP_HI: rd_mux = temp_r;
      tccp_pkg::IDX_CMPA_LO: rd_mux = cmp_buf_r[0][7:0];
      tccp_pkg::IDX_CMPA_HI: rd_mux = cmp_buf_r[0][15:8];
      tccp_pkg::IDX_CMPB_LO: rd_mux = cmp_buf_r[1][7:0];
      tccp_pkg::IDX_CMPB_HI: rd_mux = cmp_buf_r[1][15:8];
      tccp_pkg::IDX_CTRL_A: rd_mux = ctrl_a_r;
      tccp_pkg::IDX_CTRL_B: rd_mux = ctrl_b_r & 8'hcf;
      tccp_pkg::IDX_FLAGS: rd_mux = {4'h0, flags_r};
      tccp_pkg::IDX_IEN: rd_mux = {4'h0, ien_r};
      default: rd_mux = 8'h00;
    endcase
    if (paddr[1:0] != 2'b00) begin
      rd_mux = 8'h00;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else if (ce) begin
      pready_r <= acc && !pready_r;
      pslverr_r <= acc && !pready_r && !mapped;
      if (acc && !pready_r) begin
        prdata_r <= pwrite ? 32'h00000000 : {24'h000000, rd_mux};
      end
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl_a_r <= tccp_pkg::CTRL_RST;
      ctrl_b_r <= tccp_pkg::CTRL_RST;
      ien_r <= tccp_pkg::FLAGS_RST;
    end else if (ce && wr_go) begin
      if (idx == tccp_pkg::IDX_CTRL_A) begin
        ctrl_a_r <= pwdata[7:0];
      end
      if (idx == tccp_pkg::IDX_CTRL_B) begin
        ctrl_b_r <= pwdata[7:0] & 8'hcf;
      end
      if (idx == tccp_pkg::IDX_IEN) begin
        ien_r <= pwdata[3:0];
      end
    end
  end

  // shared holding byte for capture low reads and compare high writes
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      temp_r <= 8'h00;
    end else if (ce) begin
      if (rd_go && idx == tccp_pkg::IDX_CAP_LO) begin
        temp_r <= cap_val_r[15:8];
      end else if (wr_go && (idx == tccp_pkg::IDX_CMPA_HI ||
                             idx == tccp_pkg::IDX_CMPB_HI)) begin
        temp_r <= pwdata[7:0];
      end
    end
  end

  // compare registers: buffer and active value
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 2; i++) begin
        cmp_act_r[i] <= tccp_pkg::REG16_RST;
        cmp_buf_r[i] <= tccp_pkg::REG16_RST;
      end
    end else if (ce) begin
      for (int i = 0; i < 2; i++) begin
        logic [15:0] b;
        logic [5:0] lo;
        lo = (i == 0) ? tccp_pkg::IDX_CMPA_LO : tccp_pkg::IDX_CMPB_LO;
        b = cmp_buf_r[i];
        if (wr_go && idx == lo) begin
          b = {temp_r, pwdata[7:0]};
        end
        b = b & mask;
        cmp_buf_r[i] <= b;
        if (!pwm_on) begin
          cmp_act_r[i] <= b;
        end else if (latch_go) begin
          cmp_act_r[i] <= cmp_buf_r[i] & mask;
        end else begin
          cmp_act_r[i] <= cmp_act_r[i] & mask;
        end
      end
    end
  end

  // ==========================================================
  // flags (set wins over write-one clear) and requests
  always_comb begin
    flags_nxt = flags_r;
    if (wr_go && idx == tccp_pkg::IDX_FLAGS) begin
      flags_nxt = flags_nxt & ~pwdata[3:0];
    end
    flags_nxt[tccp_pkg::FL_OVF] = flags_nxt[tccp_pkg::FL_OVF] | ovf_ev;
    flags_nxt[tccp_pkg::FL_CMPA] = flags_nxt[tccp_pkg::FL_CMPA] |
                                   match_r[0];
    flags_nxt[tccp_pkg::FL_CMPB] = flags_nxt[tccp_pkg::FL_CMPB] |
                                   match_r[1];
    flags_nxt[tccp_pkg::FL_CAP] = flags_nxt[tccp_pkg::FL_CAP] |
                                  cap_edge;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      flags_r <= tccp_pkg::FLAGS_RST;
      irq_r <= tccp_pkg::FLAGS_RST;
    end else if (ce) begin
      flags_r <= flags_nxt;
      irq_r <= flags_r & ien_r & {4{gie}};
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign compare_out_a = out_r[0];
  assign compare_out_b = out_r[1];
  assign compare_out_a_oe = oe_r[0];
  assign compare_out_b_oe = oe_r[1];
  assign irq_overflow = irq_r[tccp_pkg::FL_OVF];
  assign irq_compare_a = irq_r[tccp_pkg::FL_CMPA];
  assign irq_compare_b = irq_r[tccp_pkg::FL_CMPB];
  assign irq_capture = irq_r[tccp_pkg::FL_CAP];

  // ==========================================================
  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  a_flag_after_match:
    assert property (ce && hit[0] ##1 ce |=> flags_r[tccp_pkg::FL_CMPA])
    else $error("compare flag late");
  a_no_soft_match:
    assert property (ce && !cnt_move |=> !match_r[0] && !match_r[1])
    else $error("match without count step");
  a_capture_copy:
    assert property (ce && cap_edge |=>
      cap_val_r == $past(cnt_r) && flags_r[tccp_pkg::FL_CAP])
    else $error("capture not taken");
  a_capture_ro:
    assert property (ce && wr_go && !cap_edge &&
      (idx == tccp_pkg::IDX_CAP_LO || idx == tccp_pkg::IDX_CAP_HI)
      |=> $stable(cap_val_r))
    else $error("capture changed by write");
  a_pair_write:
    assert property (ce && wr_go && !pwm_on && $stable(pwm_sel) &&
      idx == tccp_pkg::IDX_CMPA_LO
      |=> cmp_act_r[0] == {$past(temp_r), $past(pwdata[7:0])})
    else $error("compare pair write wrong");
  a_temp_on_read:
    assert property (ce && rd_go && idx == tccp_pkg::IDX_CAP_LO
      |=> temp_r == $past(cap_val_r[15:8]))
    else $error("holding byte not loaded");
  a_count_bound:
    assert property (pwm_on && $stable(pwm_sel) &&
      pwm_sel == $past(pwm_sel, 2) |-> cnt_r <= top)
    else $error("counter above top");
  a_phase_turn:
    assert property (ce && step && phase_mode && cnt_r == top
      |=> !dir_up_r && cnt_r == 16'($past(top) - 16'h0001))
    else $error("no turn at top");
  a_wrap_top:
    assert property (ce && step && wrap_mode && cnt_r == top
      |=> cnt_r == tccp_pkg::REG16_RST)
    else $error("no wrap at top");
  a_hold_till_top:
    assert property (ce && pwm_on && $stable(pwm_sel) && !latch_go
      |=> cmp_act_r[0] == $past(cmp_act_r[0] & mask))
    else $error("compare latched early");
  a_ovf_phase:
    assert property (ce && phase_mode && step &&
      cnt_r == tccp_pkg::REG16_RST |=> flags_r[tccp_pkg::FL_OVF])
    else $error("overflow flag missing");
  a_irq_gate:
    assert property (ce |=> irq_r == $past(flags_r & ien_r & {4{gie}}))
    else $error("request gating wrong");
  a_pin_zero:
    assert property (ce && phase_mode && hit[0] && mode_a ==
      tccp_pkg::OM_CLR && cmp_eff[0] == tccp_pkg::REG16_RST
      |=> !compare_out_a)
    else $error("zero compare not low");

endmodule

// ===== verilog/tccp_pkg.sv
/*
  Package of the 16-bit timer compare, capture and PWM block: register
  indices, field positions, reset values, mode codes and TOP values.
  Assumes a 32-bit APB bus with one register per aligned word.
*/
package tccp_pkg;

  // ==========================================================
  // register indices (byte address = index * 4)
  localparam int ADDR_W = 8;
  localparam logic [5:0] IDX_CAP_LO = 6'h26;
  localparam logic [5:0] IDX_CAP_HI = 6'h27;
  localparam logic [5:0] IDX_CMPB_LO = 6'h28;
  localparam logic [5:0] IDX_CMPB_HI = 6'h29;
  localparam logic [5:0] IDX_CMPA_LO = 6'h2a;
  localparam logic [5:0] IDX_CMPA_HI = 6'h2b;
  localparam logic [5:0] IDX_CTRL_B = 6'h2e;
  localparam logic [5:0] IDX_CTRL_A = 6'h2f;
  localparam logic [5:0] IDX_FLAGS = 6'h36;
  localparam logic [5:0] IDX_IEN = 6'h37;

  // ==========================================================
  // field positions
  localparam int CA_MODE_A_HI = 7;
  localparam int CA_MODE_A_LO = 6;
  localparam int CA_MODE_B_HI = 5;
  localparam int CA_MODE_B_LO = 4;
  localparam int CA_PWM_HI = 1;
  localparam int CA_PWM_LO = 0;
  localparam int CB_FILTER = 7;
  localparam int CB_EDGE = 6;
  localparam int CB_CLR_MATCH = 3;
  localparam int FL_OVF = 0;
  localparam int FL_CMPA = 1;
  localparam int FL_CMPB = 2;
  localparam int FL_CAP = 3;

  // ==========================================================
  // reset values and codes
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] REG16_RST = 16'h0000;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam logic [1:0] PWM_OFF = 2'b00;
  localparam logic [1:0] PWM_8 = 2'b01;
  localparam logic [1:0] PWM_9 = 2'b10;
  localparam logic [1:0] PWM_10 = 2'b11;
  localparam logic [1:0] OM_CLR = 2'b10;
  localparam logic [1:0] OM_SET = 2'b11;
  localparam logic [15:0] TOP_8 = 16'h00ff;
  localparam logic [15:0] TOP_9 = 16'h01ff;
  localparam logic [15:0] TOP_10 = 16'h03ff;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [3:0] FILT_ALL_HI = 4'hf;
  localparam logic [3:0] FILT_ALL_LO = 4'h0;

endpackage

// ===== tb/tccp_cpu.sv
/*
  APB master standing in for the CPU core on the register bus.
  Assumes the bench calls one task at a time, right after a clock edge.
*/
`timescale 1ns/1ps

module tccp_cpu (
  input wire logic clock,
  input wire logic pready,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // ==========================================================
  // one transfer: setup, access held until pready is sampled high
  task xfer(input logic w, input logic [5:0] idx, input logic [7:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // ==========================================================
  // 16-bit write goes upper byte first through the holding byte
  task wr16(input logic [5:0] hi_idx, input logic [15:0] v);
    xfer(1'b1, hi_idx, v[15:8]);
    xfer(1'b1, hi_idx - 6'h01, v[7:0]);
  endtask
endmodule

// ===== tb/timer16_compare_capture_pwm_tb.sv
/*
  Self-checking bench of the timer compare, capture and PWM block.
  Assumes tccp_timer16 with one wait state on APB and ce held high.
*/
`timescale 1ns/1ps

module timer16_compare_capture_pwm_tb;
  logic clock, nrst, count_en, gie, cap_pin;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic out_a, oe_a, out_b, oe_b, irq_ov, irq_a, irq_b, irq_c;
  typedef struct {logic [7:0] d; logic [7:0] m; logic e;} tccp_exp_t;
  tccp_exp_t exp_q[$];
  tccp_exp_t e;
  int mismatches, checks_done, cycles, n, top;
  logic [15:0] v;

  tccp_timer16 i_dut (.clock(clock), .nrst(nrst), .ce(1'b1),
    .count_en(count_en), .gie(gie), .capture_input_pin(cap_pin),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .compare_out_a(out_a), .compare_out_a_oe(oe_a),
    .compare_out_b(out_b), .compare_out_b_oe(oe_b),
    .irq_overflow(irq_ov), .irq_compare_a(irq_a),
    .irq_compare_b(irq_b), .irq_capture(irq_c));

  tccp_cpu i_cpu (.clock(clock), .pready(pready), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  // ==========================================================
  // clock, timeout and verdict
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task give_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      give_verdict();
    end
  end

  task chk(input string s, input logic [15:0] x, input logic [15:0] g);
    checks_done++;
    if (g !== x) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", s, x, g);
    end
  endtask

  // ==========================================================
  // read results are taken off the queue as they complete
  always @(posedge clock) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (exp_q.size() == 0) begin
        chk("read queue", 16'h0001, 16'h0000);
      end else begin
        e = exp_q.pop_front();
        chk("prdata", {8'h00, e.d & e.m}, {8'h00, prdata[7:0] & e.m});
        chk("pslverr", {15'h0000, e.e}, {15'h0000, pslverr});
      end
    end
  end

  task wr(input logic [5:0] i, input logic [7:0] d);
    i_cpu.xfer(1'b1, i, d);
  endtask

  task rd(input logic [5:0] i, input logic [7:0] d,
          input logic [7:0] m = 8'hff, input logic er = 1'b0);
    exp_q.push_back('{d, m, er});
    i_cpu.xfer(1'b0, i, 8'h00);
  endtask

  task steps(input int k);
    count_en <= 1'b1;
    repeat (k) @(posedge clock);
    count_en <= 1'b0;
  endtask

  // cycles from the current edge to the next rise of compare_out_a
  task rise(output int k);
    k = 0;
    while (out_a !== 1'b0 && k < 5000) begin
      @(posedge clock);
      k++;
    end
    while (out_a !== 1'b1 && k < 5000) begin
      @(posedge clock);
      k++;
    end
  endtask

  // ==========================================================
  // main sequence
  initial begin
    nrst = 1'b0;
    count_en = 1'b0;
    gie = 1'b0;
    cap_pin = 1'b0;
    void'($urandom(8971));
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    for (int i = 6'h26; i <= 6'h2b; i++) rd(i[5:0], 8'h00);
    v = 16'($urandom);
    i_cpu.wr16(tccp_pkg::IDX_CMPA_HI, v);
    rd(tccp_pkg::IDX_CMPA_LO, v[7:0]);
    rd(tccp_pkg::IDX_CMPA_HI, v[15:8]);
    wr(tccp_pkg::IDX_CMPB_HI, ~v[15:8]);
    rd(tccp_pkg::IDX_CMPB_HI, 8'h00);
    wr(tccp_pkg::IDX_CMPA_HI, v[7:0]);
    wr(tccp_pkg::IDX_CMPB_LO, v[15:8]);
    rd(tccp_pkg::IDX_CMPB_HI, v[7:0]);
    rd(tccp_pkg::IDX_CMPA_HI, v[15:8]);
    wr(tccp_pkg::IDX_CAP_LO, 8'hff);
    wr(tccp_pkg::IDX_CAP_HI, 8'hff);
    rd(tccp_pkg::IDX_CAP_LO, 8'h00);
    rd(tccp_pkg::IDX_CAP_HI, 8'h00);
    rd(6'h10, 8'h00, 8'hff, 1'b1);
    // compare match, flag and interrupt
    i_cpu.wr16(tccp_pkg::IDX_CMPA_HI, 16'h0005);
    wr(tccp_pkg::IDX_FLAGS, 8'h0f);
    i_cpu.wr16(tccp_pkg::IDX_CMPB_HI, 16'h0000);
    rd(tccp_pkg::IDX_FLAGS, 8'h00, 8'h06);
    wr(tccp_pkg::IDX_IEN, 8'h02);
    gie <= 1'b1;
    steps(10);
    rd(tccp_pkg::IDX_FLAGS, 8'h02, 8'h07);
    chk("irq_compare_a", 16'h0001, {15'h0000, irq_a});
    gie <= 1'b0;
    repeat (3) @(posedge clock);
    chk("irq_compare_a", 16'h0000, {15'h0000, irq_a});
    // capture on rising, falling and filtered edges
    wr(tccp_pkg::IDX_CTRL_B, 8'h40);
    cap_pin <= 1'b1;
    repeat (8) @(posedge clock);
    rd(tccp_pkg::IDX_FLAGS, 8'h08, 8'h08);
    rd(tccp_pkg::IDX_CAP_LO, 8'h0a);
    rd(tccp_pkg::IDX_CAP_HI, 8'h00);
    wr(tccp_pkg::IDX_CTRL_B, 8'h00);
    steps(3);
    cap_pin <= 1'b0;
    repeat (8) @(posedge clock);
    rd(tccp_pkg::IDX_CAP_LO, 8'h0d);
    wr(tccp_pkg::IDX_CTRL_B, 8'hc0);
    wr(tccp_pkg::IDX_FLAGS, 8'h0f);
    cap_pin <= 1'b1;
    repeat (2) @(posedge clock);
    cap_pin <= 1'b0;
    repeat (8) @(posedge clock);
    rd(tccp_pkg::IDX_FLAGS, 8'h00, 8'h08);
    steps(2);
    cap_pin <= 1'b1;
    repeat (12) @(posedge clock);
    rd(tccp_pkg::IDX_CAP_LO, 8'h0f);
    // PWM periods for every resolution in both modes
    count_en <= 1'b1;
    for (int r = 1; r <= 3; r++) begin
      for (int c = 0; c < 2; c++) begin
        top = (256 << (r - 1)) - 1;
        v = 16'(1 + $urandom % (top - 1));
        wr(tccp_pkg::IDX_CTRL_B, (c == 1) ? 8'h08 : 8'h00);
        wr(tccp_pkg::IDX_CTRL_A, 8'h80 | 8'(r));
        i_cpu.wr16(tccp_pkg::IDX_CMPA_HI, v);
        rd(tccp_pkg::IDX_CMPA_LO, v[7:0]);
        rise(n);
        rise(n);
        rise(n);
        chk("period", 16'((c == 1) ? top + 1 : 2 * top), 16'(n));
        chk("oe_a", 16'h0001, {15'h0000, oe_a});
      end
    end
    rd(tccp_pkg::IDX_FLAGS, 8'h01, 8'h01);
    // phase-correct with zero compare gives fixed levels
    i_cpu.wr16(tccp_pkg::IDX_CMPA_HI, 16'h0000);
    i_cpu.wr16(tccp_pkg::IDX_CMPB_HI, 16'h0000);
    wr(tccp_pkg::IDX_CTRL_B, 8'h00);
    wr(tccp_pkg::IDX_CTRL_A, 8'hb1);
    repeat (1100) @(posedge clock);
    for (int i = 0; i < 10; i++) begin
      repeat (50) @(posedge clock);
      chk("out_a", 16'h0000, {15'h0000, out_a});
      chk("out_b", 16'h0001, {15'h0000, out_b});
    end
    // every flag is set by now: overflow, compare B and capture requests follow the enables
    wr(tccp_pkg::IDX_IEN, 8'h0f);
    gie <= 1'b1;
    repeat (3) @(posedge clock);
    chk("irq_overflow", 16'h0001, {15'h0000, irq_ov});
    chk("irq_compare_b", 16'h0001, {15'h0000, irq_b});
    chk("irq_capture", 16'h0001, {15'h0000, irq_c});
    give_verdict();
  end
endmodule
